// ### verilog/interleave_pkg.sv
// Shared constants, types and helpers for the interleaved PCM backplane link
package interleave_pkg;
    // ------------------------------------------------------------
    // Device configuration register
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_OFFSET        = 8'h1c;
    localparam logic [7:0] CFG_RESET         = 8'h00;
    localparam logic [7:0] CFG_WRITABLE_MASK = 8'h7f;
    localparam int         SLOT_SEL_LSB      = 0;
    localparam int         SLOT_W            = 3;
    localparam int         ENABLE_BIT        = 3;
    localparam int         RATE_LSB          = 4;
    localparam int         RATE_W            = 2;
    localparam int         TXCLK_SEL_BIT     = 6;

    typedef enum logic [RATE_W-1:0] {
        RATE_2M048,
        RATE_4M096,
        RATE_8M192,
        RATE_16M384
    } bus_rate_t;

    // ------------------------------------------------------------
    // Bus framing
    // ------------------------------------------------------------
    localparam int                   SLOT_BIT_W    = 3;
    localparam int                   FRAME_CNT_W   = 11;
    localparam logic [FRAME_CNT_W:0] E1_FRAME_BITS = 12'h100;
    localparam logic [7:0]           IDLE_BYTE     = 8'hff;
    localparam int                   FIFO_DEPTH    = 8;
    localparam int                   PCM_W         = 8;

    // ------------------------------------------------------------
    // Controller APB map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET        = 8'h00;
    localparam logic [7:0] RXDATA_OFFSET      = 8'h04;
    localparam logic [7:0] DEVREG_OFFSET      = 8'h08;
    localparam logic [3:0] CTRL_RESET         = 4'h0;
    localparam int         CTRL_W             = 4;
    localparam int         CTRL_RUN_BIT       = 0;
    localparam int         CTRL_RATE_LSB      = 1;
    localparam int         CTRL_GND_TSYNC_BIT = 3;
    localparam int         RX_SLOT_LSB        = 8;
    localparam int         RX_OVERRUN_BIT     = 30;
    localparam int         RX_VALID_BIT       = 31;
    localparam int         DEVREG_ADDR_LSB    = 8;
    localparam int         DEVREG_READ_BIT    = 16;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS  = 20;
    localparam int LINK_PERIOD_NS   = 160;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);

    function automatic logic [SLOT_W-1:0] slot_mask(input bus_rate_t rate);
        logic [3:0] n;
        n = (4'h1 << rate) - 4'h1;
        return n[SLOT_W-1:0];
    endfunction : slot_mask

    function automatic logic [FRAME_CNT_W-1:0] frame_last_bit(input bus_rate_t rate);
        logic [FRAME_CNT_W:0] n;
        n = (E1_FRAME_BITS << rate) - 12'h001;
        return n[FRAME_CNT_W-1:0];
    endfunction : frame_last_bit
endpackage : interleave_pkg

// ### verilog/interleave_link_if.sv
// Pin-level link between one transceiver and the backplane controller
`timescale 1ns/1ps
`default_nettype none
interface interleave_link_if;
    logic       sys_clock;
    logic       rx_frame_sync;
    logic       bus_data_out;
    logic       bus_data_oe_n;
    logic       bus_data;
    logic       tsync_dev_out;
    logic       tsync_dev_oe_n;
    logic       tsync_host_out;
    logic       tsync_host_oe_n;
    logic       tsync_in;
    logic       reg_req;
    logic       reg_we;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_ack;

    // Undriven bus floats high through a pull-up
    assign bus_data = bus_data_oe_n ? 1'b1 : bus_data_out;
    assign tsync_in = !tsync_dev_oe_n ? tsync_dev_out :
                      (!tsync_host_oe_n ? tsync_host_out : 1'b0);

    modport device (
        input  sys_clock, rx_frame_sync, tsync_in, reg_req, reg_we, reg_addr, reg_wdata,
        output bus_data_out, bus_data_oe_n, tsync_dev_out, tsync_dev_oe_n, reg_rdata, reg_ack
    );
    modport host (
        output sys_clock, rx_frame_sync, tsync_host_out, tsync_host_oe_n,
        output reg_req, reg_we, reg_addr, reg_wdata,
        input  bus_data, reg_rdata, reg_ack
    );
endinterface : interleave_link_if
`default_nettype wire

// ### verilog/pcm_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    // DEPTH must be a power of two so the pointers wrap naturally
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             ready_reg;

    wire push = in_valid && ready_reg;
    wire pop  = out_ready && (count_reg != '0);

    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready   = ready_reg;
    assign out_valid  = count_reg != '0;
    assign out_data   = mem_reg[rd_ptr_reg];

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b1;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            ready_reg <= count_next != (AW+1)'(DEPTH);
        end
    end
endmodule : pcm_fifo
`default_nettype wire

// ### verilog/interleave_device.sv
// Transceiver end: interleave configuration register and slot driver
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// How it works
// - Merge whole channels onto the shared bus
// - Rate field picks 1, 2, 4 or 8 devices
// - Controller enables every receive elastic store first
// - Controller gives each device a unique slot
// - Slot field is a binary device index
// - Transmit sync pin is output or grounded input
// - Outside world supplies no transmit sync
// - Internal transmit sync follows receive sync while interleaving is on
// - Input transmit sync pin is disconnected when enabled
// - Bit 6 picks transmit clock pin or system clock
// - Bit 3 turns interleaving off or on
// - Software writes zero to bit 7
// - Configuration register sits at offset 1c
// ------------------------------------------------------------
module interleave_device
    import interleave_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             rst,
    interleave_link_if.device     link,
    input  wire logic [PCM_W-1:0] pcm_data,
    input  wire logic             pcm_valid,
    output logic                  pcm_ready,
    input  wire logic             tx_clock_pin,
    input  wire logic             tsync_pin_is_output,
    output logic                  tx_clock_out,
    output logic                  tx_frame_sync,
    output logic                  frame_locked
);
    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    logic [7:0] cfg_reg;
    logic       reg_ack_reg;
    logic [7:0] reg_rdata_reg;

    wire cfg_hit = link.reg_req && (link.reg_addr == CFG_OFFSET);

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg       <= CFG_RESET;
            reg_ack_reg   <= 1'b0;
            reg_rdata_reg <= '0;
        end else begin
            reg_ack_reg   <= link.reg_req;
            // Unmapped addresses read zero and ignore writes
            reg_rdata_reg <= cfg_hit ? (cfg_reg & CFG_WRITABLE_MASK) : '0;
            if (cfg_hit && link.reg_we) begin
                // Bit 7 is not stored, so a stray one cannot leak into behaviour
                cfg_reg <= link.reg_wdata & CFG_WRITABLE_MASK;
            end
        end
    end

    assign link.reg_ack   = reg_ack_reg;
    assign link.reg_rdata = reg_rdata_reg;

    wire                  enable    = cfg_reg[ENABLE_BIT];
    wire                  txclk_sel = cfg_reg[TXCLK_SEL_BIT];
    wire     [SLOT_W-1:0] slot_sel  = cfg_reg[SLOT_SEL_LSB +: SLOT_W];
    bus_rate_t            rate;
    assign rate = bus_rate_t'(cfg_reg[RATE_LSB +: RATE_W]);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W  = 4;
    localparam int S_SCLK  = 3;
    localparam int S_FSYNC = 2;
    localparam int S_TSPIN = 1;
    localparam int S_TXCLK = 0;

    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic              sclk_prev_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_reg      <= '0;
            sync_reg      <= '0;
            sclk_prev_reg <= 1'b0;
        end else begin
            meta_reg      <= {link.sys_clock, link.rx_frame_sync, link.tsync_in, tx_clock_pin};
            sync_reg      <= meta_reg;
            sclk_prev_reg <= sync_reg[S_SCLK];
        end
    end

    wire sclk_s    = sync_reg[S_SCLK];
    wire fsync_s   = sync_reg[S_FSYNC];
    wire tspin_s   = sync_reg[S_TSPIN];
    wire txclk_s   = sync_reg[S_TXCLK];
    wire sclk_rise = sclk_s && !sclk_prev_reg;

    // ------------------------------------------------------------
    // Transmit PCM buffer
    // ------------------------------------------------------------
    logic [PCM_W-1:0] fifo_data;
    logic             fifo_valid;
    logic             fifo_pop;

    pcm_fifo #(
        .WIDTH (PCM_W),
        .DEPTH (FIFO_DEPTH_P)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_data   (pcm_data),
        .in_valid  (pcm_valid),
        .in_ready  (pcm_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ------------------------------------------------------------
    // Bit position and slot decode
    // ------------------------------------------------------------
    // Frame sync is seen during the last bit, so the next bit is bit 0
    logic [FRAME_CNT_W-1:0] bit_cnt_reg;
    logic                   locked_reg;

    wire [FRAME_CNT_W-1:0] bit_cnt_next = fsync_s ? '0 : bit_cnt_reg + 1'b1;
    wire [SLOT_W-1:0]      slot_now     = bit_cnt_next[SLOT_BIT_W +: SLOT_W]
                                          & slot_mask(rate);
    wire                   byte_start   = bit_cnt_next[SLOT_BIT_W-1:0] == '0;
    wire                   own_slot     = enable && (locked_reg || fsync_s)
                                          && (slot_now == slot_sel);
    wire [PCM_W-1:0]       load_byte    = fifo_valid ? fifo_data : IDLE_BYTE;

    // A whole byte leaves the buffer at the start of each owned channel while it holds one; an empty buffer sends the idle byte
    assign fifo_pop = sclk_rise && own_slot && byte_start && fifo_valid;

    always_ff @(posedge clock) begin
        if (rst) begin
            bit_cnt_reg <= '0;
            locked_reg  <= 1'b0;
        end else if (!enable) begin
            locked_reg  <= 1'b0;
        end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_next;
            if (fsync_s) begin
                locked_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Shared bus driver
    // ------------------------------------------------------------
    logic [PCM_W-1:0] shift_reg;
    logic             bus_out_reg;
    logic             bus_oe_n_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            shift_reg    <= '0;
            bus_out_reg  <= 1'b1;
            bus_oe_n_reg <= 1'b1;
        end else if (!enable) begin
            // Let go at once so a disabled device never collides
            bus_oe_n_reg <= 1'b1;
        end else if (sclk_rise) begin
            bus_oe_n_reg <= !own_slot;
            if (own_slot && byte_start) begin
                bus_out_reg <= load_byte[PCM_W-1];
                shift_reg   <= {load_byte[PCM_W-2:0], 1'b0};
            end else if (own_slot) begin
                bus_out_reg <= shift_reg[PCM_W-1];
                shift_reg   <= {shift_reg[PCM_W-2:0], 1'b0};
            end
        end
    end

    assign link.bus_data_out  = bus_out_reg;
    assign link.bus_data_oe_n = bus_oe_n_reg;

    // ------------------------------------------------------------
    // Transmit sync and transmit clock
    // ------------------------------------------------------------
    // With interleaving on, the pin never reaches the internal sync
    wire tx_sync_next = enable ? fsync_s
                               : (tsync_pin_is_output ? 1'b0 : tspin_s);

    logic tx_sync_reg;
    logic tsync_out_reg;
    logic tsync_oe_n_reg;
    logic tx_clock_reg;
    logic frame_locked_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_sync_reg      <= 1'b0;
            tsync_out_reg    <= 1'b0;
            tsync_oe_n_reg   <= 1'b1;
            tx_clock_reg     <= 1'b0;
            frame_locked_reg <= 1'b0;
        end else begin
            tx_sync_reg      <= tx_sync_next;
            tsync_out_reg    <= tx_sync_next;
            tsync_oe_n_reg   <= !tsync_pin_is_output;
            tx_clock_reg     <= txclk_sel ? sclk_s : txclk_s;
            frame_locked_reg <= locked_reg;
        end
    end

    assign link.tsync_dev_out  = tsync_out_reg;
    assign link.tsync_dev_oe_n = tsync_oe_n_reg;
    assign tx_frame_sync       = tx_sync_reg;
    assign tx_clock_out        = tx_clock_reg;
    assign frame_locked        = frame_locked_reg;
endmodule : interleave_device
`default_nettype wire

// ### verilog/interleave_host.sv
// Backplane controller end: APB slave, bus clock and sync, slot capture
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module interleave_host
    import interleave_pkg::*;
#(
    parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    interleave_link_if.host  link
);
    // ------------------------------------------------------------
    // Control register and bus clock divider
    // ------------------------------------------------------------
    localparam int DIV_W = $clog2(HALF_CYCLES + 1);

    logic [CTRL_W-1:0] ctrl_reg;
    logic [DIV_W-1:0]  div_reg;
    logic              sclk_reg;

    wire       run       = ctrl_reg[CTRL_RUN_BIT];
    bus_rate_t rate;
    // Every device on the bus must be set to this same rate
    assign rate = bus_rate_t'(ctrl_reg[CTRL_RATE_LSB +: RATE_W]);
    wire       div_end   = div_reg == DIV_W'(HALF_CYCLES - 1);
    wire       tick_rise = run && div_end && !sclk_reg;
    wire       tick_fall = run && div_end && sclk_reg;

    always_ff @(posedge clock) begin
        if (rst || !run) begin
            div_reg  <= '0;
            sclk_reg <= 1'b0;
        end else begin
            div_reg  <= div_end ? '0 : div_reg + 1'b1;
            sclk_reg <= div_end ? !sclk_reg : sclk_reg;
        end
    end

    // ------------------------------------------------------------
    // Frame counter, sync and capture
    // ------------------------------------------------------------
    logic [FRAME_CNT_W-1:0] hcnt_reg;
    logic                   hlock_reg;
    logic                   fsync_reg;
    logic [1:0]             data_sync_reg;
    logic [PCM_W-1:0]       rx_shift_reg;
    logic [PCM_W-1:0]       rx_byte_reg;
    logic [SLOT_W-1:0]      rx_slot_reg;
    logic                   rx_valid_reg;
    logic                   rx_overrun_reg;
    logic                   rx_pop;

    wire                   last_bit  = hcnt_reg == frame_last_bit(rate);
    wire [PCM_W-1:0]       shift_in  = {rx_shift_reg[PCM_W-2:0], data_sync_reg[1]};
    wire                   byte_done = tick_rise && hlock_reg
                                       && (hcnt_reg[SLOT_BIT_W-1:0] == '1);
    wire [SLOT_W-1:0]      slot_now  = hcnt_reg[SLOT_BIT_W +: SLOT_W] & slot_mask(rate);

    always_ff @(posedge clock) begin
        if (rst || !run) begin
            hcnt_reg      <= '1;
            hlock_reg     <= 1'b0;
            fsync_reg     <= 1'b0;
            data_sync_reg <= '1;
            rx_shift_reg  <= '0;
        end else begin
            data_sync_reg <= {data_sync_reg[0], link.bus_data};
            if (tick_fall) begin
                fsync_reg <= last_bit;
            end
            if (tick_rise) begin
                hcnt_reg     <= last_bit ? '0 : hcnt_reg + 1'b1;
                hlock_reg    <= hlock_reg || last_bit;
                rx_shift_reg <= shift_in;
            end
        end
    end

    // A new byte wins over a read that clears the flag in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_byte_reg    <= '0;
            rx_slot_reg    <= '0;
            rx_valid_reg   <= 1'b0;
            rx_overrun_reg <= 1'b0;
        end else if (byte_done) begin
            rx_byte_reg    <= shift_in;
            rx_slot_reg    <= slot_now;
            rx_valid_reg   <= 1'b1;
            rx_overrun_reg <= rx_overrun_reg || (rx_valid_reg && !rx_pop);
        end else if (rx_pop) begin
            rx_valid_reg   <= 1'b0;
            rx_overrun_reg <= 1'b0;
        end
    end

    assign link.sys_clock     = sclk_reg;
    assign link.rx_frame_sync = fsync_reg;
    // Transmit sync is never supplied; optionally held at ground
    assign link.tsync_host_out  = 1'b0;
    assign link.tsync_host_oe_n = !ctrl_reg[CTRL_GND_TSYNC_BIT];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    logic        pready_reg;
    logic        pslverr_reg;
    logic [31:0] prdata_reg;
    logic        dev_wait_reg;
    logic        req_reg;
    logic        we_reg;
    logic [7:0]  addr_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  dev_rdata_reg;

    wire         access     = psel && penable;
    wire         hit_ctrl   = paddr == CTRL_OFFSET;
    wire         hit_rx     = paddr == RXDATA_OFFSET;
    wire         hit_dev    = paddr == DEVREG_OFFSET;
    wire         start      = access && !pready_reg && !dev_wait_reg && !req_reg;
    wire         commit     = access && pready_reg;
    wire [31:0]  rx_word    = {rx_valid_reg, rx_overrun_reg, 19'h0, rx_slot_reg, rx_byte_reg};
    wire [31:0]  read_mux   = hit_ctrl ? {28'h0, ctrl_reg} : (hit_rx ? rx_word :
                              (hit_dev ? {24'h0, dev_rdata_reg} : '0));

    assign rx_pop = commit && !pwrite && hit_rx;

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg      <= CTRL_RESET;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
            prdata_reg    <= '0;
            dev_wait_reg  <= 1'b0;
            req_reg       <= 1'b0;
            we_reg        <= 1'b0;
            addr_reg      <= '0;
            wdata_reg     <= '0;
            dev_rdata_reg <= '0;
        end else begin
            req_reg <= 1'b0;
            if (start && hit_dev && pwrite) begin
                req_reg      <= 1'b1;
                dev_wait_reg <= 1'b1;
                we_reg       <= !pwdata[DEVREG_READ_BIT];
                addr_reg     <= pwdata[DEVREG_ADDR_LSB +: 8];
                wdata_reg    <= pwdata[7:0];
            end else if (start) begin
                pready_reg  <= 1'b1;
                pslverr_reg <= !(hit_ctrl || hit_rx || hit_dev);
                prdata_reg  <= pwrite ? '0 : read_mux;
            end
            if (dev_wait_reg && link.reg_ack) begin
                dev_wait_reg  <= 1'b0;
                dev_rdata_reg <= link.reg_rdata;
                pready_reg    <= 1'b1;
                pslverr_reg   <= 1'b0;
                prdata_reg    <= {24'h0, link.reg_rdata};
            end
            if (commit) begin
                pready_reg  <= 1'b0;
                pslverr_reg <= 1'b0;
                if (pwrite && hit_ctrl) begin
                    ctrl_reg <= pwdata[CTRL_W-1:0];
                end
            end
        end
    end

    assign link.reg_req   = req_reg;
    assign link.reg_we    = we_reg;
    assign link.reg_addr  = addr_reg;
    assign link.reg_wdata = wdata_reg;
    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
endmodule : interleave_host
`default_nettype wire

// ### tb/interleave_props.sv
// Checker for the link between the host and device ends
`timescale 1ns/1ps
`default_nettype none
module interleave_props (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       sys_clock,
    input wire logic       rx_frame_sync,
    input wire logic       bus_data_oe_n,
    input wire logic       tsync_host_out,
    input wire logic       tsync_host_oe_n,
    input wire logic       reg_req,
    input wire logic       reg_we,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_ack
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ack; reg_req |=> reg_ack; endproperty
    a_ack: assert property (p_ack) else $error("register ack late");
    property p_ack_src; reg_ack |-> $past(reg_req); endproperty
    a_ack_src: assert property (p_ack_src) else $error("stray register ack");
    property p_unmapped; reg_req && !reg_we && reg_addr != 8'h1c |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_bit7; reg_ack |-> !reg_rdata[7]; endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 reads one");
    property p_release;
        reg_req && reg_we && reg_addr == 8'h1c && !reg_wdata[3] |=> ##[0:1] bus_data_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("bus kept after disable");
    property p_gnd; !tsync_host_oe_n |-> !tsync_host_out; endproperty
    a_gnd: assert property (p_gnd) else $error("sync pin not grounded");
    // Sync marks exactly one bit period of 8 clocks
    property p_fsync; $rose(rx_frame_sync) |-> rx_frame_sync [*8] ##1 !rx_frame_sync; endproperty
    a_fsync: assert property (p_fsync) else $error("frame sync width");
    property p_backplane_sys_clock; $rose(sys_clock) |-> sys_clock [*4] ##1 !sys_clock [*4]; endproperty
    a_backplane_sys_clock: assert property (p_backplane_sys_clock) else $error("bit clock period");
    c_drive: cover property (!bus_data_oe_n);
    c_write: cover property (reg_req && reg_we);
    c_sync: cover property ($rose(rx_frame_sync));
endmodule : interleave_props
`default_nettype wire

// ### tb/interleaved_pcm_backplane_tb.sv
// Bench joining host and device ends over the interleaved link
`timescale 1ns/1ps
`default_nettype none
module interleaved_pcm_backplane_tb;
    import interleave_pkg::*;
    logic        clock = '0, rst = '1, psel = '0, penable = '0, pwrite = '0;
    logic [7:0]  paddr = '0, pcm_data = 8'h3c;
    logic [31:0] pwdata = '0, prdata, r;
    logic        pready, pslverr, err, pcm_valid = '0, pcm_ready;
    logic        tx_clock_pin = '0, tx_clock_out, tx_frame_sync, frame_locked;
    int          n_fail = 0, checks = 0;
    always #10 clock = ~clock;
    interleave_link_if link ();
    interleave_host interleave_host_inst (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    interleave_device interleave_device_inst (.clock(clock), .rst(rst), .link(link),
        .pcm_data(pcm_data), .pcm_valid(pcm_valid), .pcm_ready(pcm_ready),
        .tx_clock_pin(tx_clock_pin), .tsync_pin_is_output(1'h0), .tx_clock_out(tx_clock_out),
        .tx_frame_sync(tx_frame_sync), .frame_locked(frame_locked));
    interleave_props interleave_props_inst (.clock(clock), .rst(rst),
        .sys_clock(link.sys_clock), .rx_frame_sync(link.rx_frame_sync),
        .bus_data_oe_n(link.bus_data_oe_n), .tsync_host_out(link.tsync_host_out),
        .tsync_host_oe_n(link.tsync_host_oe_n), .reg_req(link.reg_req), .reg_we(link.reg_we),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .reg_ack(link.reg_ack));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic close_out;
        $display("mismatches %0d of %0d checks", n_fail, checks);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    // Waits on pready with no assumed latency; the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        r = prdata;
        err = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask : apb
    task automatic dev(input logic rd, input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, 8'h08, {15'h0, rd, a, d});
    endtask : dev
    task automatic t_regs;
        apb(1'h0, 8'h10, '0);
        check(err, 1'h1);
        dev(1'h1, 8'h1c, 8'h00);
        check(r[7:0], 8'h00);
        dev(1'h0, 8'h1c, 8'hff);
        dev(1'h1, 8'h1c, 8'h00);
        check(r[7:0], 8'h7f);
        apb(1'h0, 8'h08, '0);
        check(r[7:0], 8'h7f);
        dev(1'h1, 8'h1d, 8'h00);
        check(r[7:0], 8'h00);
    endtask : t_regs
    task automatic t_clk;
        pcm_valid <= 1'h1;
        dev(1'h0, 8'h1c, 8'h00);
        tx_clock_pin <= 1'h1;
        repeat (12) @(posedge clock);
        check(pcm_ready, 1'h0);
        check(tx_clock_out, 1'h1);
        dev(1'h0, 8'h1c, 8'h40);
        repeat (6) @(posedge clock);
        check(tx_clock_out, 1'h0);
    endtask : t_clk
    task automatic t_slot;
        dev(1'h0, 8'h1c, 8'h19);
        apb(1'h1, 8'h00, 32'h0000000b);
        @(posedge link.rx_frame_sync);
        repeat (4) @(posedge clock);
        check(tx_frame_sync, 1'h1);
        // Slot 1 carries the queued byte, slot 0 floats high
        for (int i = 0; i < 8; i++) begin
            do apb(1'h0, 8'h04, '0); while (r[31] !== 1'h1);
            check(r[10:9], 2'h0);
            check(r[7:0], r[8] ? 8'h3c : 8'hff);
        end
        check(frame_locked, 1'h1);
        dev(1'h0, 8'h1c, 8'h11);
        repeat (100) @(posedge clock);
        check(link.bus_data_oe_n, 1'h1);
        check(frame_locked, 1'h0);
    endtask : t_slot
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        t_regs();
        t_clk();
        t_slot();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        close_out();
    end
endmodule : interleaved_pcm_backplane_tb
`default_nettype wire
